// file: pdc_pkg.sv
package pdc_pkg;
	// Sources and address decode
	localparam int NUM_CH = 9;
	localparam int NUM_SRC = 10;
	localparam logic [3:0] CRC_IDX = 4'h9;
	localparam logic [3:0] LAST_RST = 4'h9;
	localparam logic [3:0] BLK_CRC = 4'he;
	localparam logic [3:0] BLK_GLB = 4'hf;
	// Channel offsets
	localparam logic [7:0] OFS_CTL = 8'h00;
	localparam logic [7:0] OFS_SRC = 8'h04;
	localparam logic [7:0] OFS_DST = 8'h08;
	localparam logic [7:0] OFS_CNT = 8'h0c;
	localparam logic [7:0] OFS_CSRC = 8'h14;
	localparam logic [7:0] OFS_CDST = 8'h18;
	localparam logic [7:0] OFS_CCNT = 8'h1c;
	localparam logic [7:0] OFS_IE = 8'h20;
	localparam logic [7:0] OFS_IS = 8'h24;
	localparam logic [7:0] OFS_BUF = 8'h80;
	// Checksum offsets
	localparam logic [7:0] OFS_WDATA = 8'h80;
	localparam logic [7:0] OFS_SEED = 8'h84;
	localparam logic [7:0] OFS_SUM = 8'h88;
	// Global offsets
	localparam logic [7:0] OFS_SEL0 = 8'h04;
	localparam logic [7:0] OFS_SEL1 = 8'h08;
	localparam logic [7:0] OFS_GIS = 8'h0c;
	localparam logic [7:0] OFS_SEL2 = 8'h10;
	// Field positions
	localparam int B_EN = 0;
	localparam int B_SRST = 1;
	localparam int F_MODE = 2;
	localparam int F_SSTEP = 4;
	localparam int F_DSTEP = 6;
	localparam int F_WID = 19;
	localparam int B_TRIG = 23;
	localparam int B_IREV = 24;
	localparam int B_OREV = 25;
	localparam int B_ICOM = 26;
	localparam int B_OCOM = 27;
	localparam int F_WLEN = 28;
	localparam int F_POLY = 30;
	localparam int B_ABORT = 0;
	localparam int B_DONE = 1;
	localparam int B_GIS_CRC = 16;
	// Reset values
	localparam logic [31:0] RST_CHECKSUM_CONTROL = 32'h2000_0000;
	localparam logic [31:0] RST_SEED = 32'hffff_ffff;
	localparam logic [31:0] RST_SUM = 32'hffff_ffff;
	localparam logic [1:0] RST_IE = 2'h1;
	localparam logic [7:0] RST_SEL = 8'hff;
	// Codes
	localparam logic [1:0] MODE_M2M = 2'h0;
	localparam logic [1:0] PW_BYTE = 2'h1;
	localparam logic [1:0] PW_HALF = 2'h2;
	localparam logic [1:0] WL_BYTE = 2'h0;
	localparam logic [1:0] WL_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	// Polynomials: CCITT, 8, 16, 32
	localparam logic [31:0] POLY_TAB [4] = '{32'h0000_1021, 32'h0000_0007, 32'h0000_8005, 32'h04c1_1db7};
	localparam logic [31:0] TOP_TAB [4] = '{32'h0000_8000, 32'h0000_0080, 32'h0000_8000, 32'h8000_0000};
	localparam int WID_TAB [4] = '{16, 8, 16, 32};

	typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_CRC} pdc_fsm_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [31:0] wdata;
	} pdc_rb_req_t;

	typedef struct packed {
		logic req;
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} pdc_mb_req_t;

	typedef struct packed {
		logic ack;
		logic err;
		logic [31:0] rdata;
	} pdc_mb_rsp_t;

	typedef struct packed {
		logic en;
		logic busy;
		logic err_hold;
		logic [1:0] width;
		logic [1:0] mode;
		logic [1:0] sstep;
		logic [1:0] dstep;
		logic [31:0] src;
		logic [31:0] dst;
		logic [31:0] csrc;
		logic [31:0] cdst;
		logic [31:0] buffer;
		logic [15:0] cnt;
		logic [15:0] ccnt;
		logic [1:0] ie;
		logic [1:0] flg;
		logic [7:0] sel;
	} pdc_chan_t;
endpackage : pdc_pkg

// file: pdc_engine.sv
`timescale 1ns/1ps
// Functional notes
// - Nine one-way transfer channels plus one checksum channel.
// - Round-robin arbitration; after reset channel 0 is served first, the checksum channel last.
// - Each channel holds one word between its read and its write.
// - Peripheral width word, half-word or byte from control bits 20:19.
// - Source and destination addresses increment or stay fixed, bits 5:4 and 7:6.
// - Mode bits 3:2 pick peripheral-to-memory, memory-to-peripheral or memory-to-memory.
// - Clearing enable bit 0 stops the channel.
// - Trigger bit 23 starts a block; runs until remaining count is zero.
// - Block done sets status bit 1; enable bit 1 raises interrupt; write one clears.
// - After a block the channel idles until triggered again.
// - Error halts the channel; restart needs soft reset bit 1, enable and trigger.
// - Checksum polynomial chosen by control bits 31:30.
// - Polynomials are CCITT-16, CRC-8, CRC-16 and CRC-32.
// - Enable without trigger takes CPU writes; enable with trigger fetches by DMA.
// - CPU write length bits 29:28: byte, half, word in 1, 2, 4 cycles.
// - Bits 24 to 27 reverse or complement input and result.
// - Checksum reset bit 1 loads the seed, keeps control, clears itself.
// - An input write folds into the checksum only when enabled, not triggered and the last word is folded; result register reads it.
// - Fetch uses word-aligned address and 16-bit byte count of any length.
// - Fetch completion sets fetch status bit 1; checksum then valid.
module pdc_engine import pdc_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register port
	input pdc_rb_req_t rb_req,
	output logic [31:0] rb_rdata,
	// Memory bus master
	output pdc_mb_req_t mb_req,
	input pdc_mb_rsp_t mb_rsp,
	// Peripheral requests and interrupt
	input wire logic [15:0] periph_req,
	output logic irq
);
	typedef struct packed {
		pdc_chan_t [NUM_CH-1:0] ch;
		pdc_fsm_t st;
		logic [3:0] cur;
		logic [3:0] last;
		pdc_mb_req_t mb;
		logic [31:0] rdata;
		logic irq;
		logic crc_en;
		logic crc_trig;
		logic crc_irev;
		logic crc_orev;
		logic crc_icom;
		logic crc_ocom;
		logic [1:0] crc_wlen;
		logic [1:0] crc_poly;
		logic [31:0] crc_seed;
		logic [31:0] crc_sum;
		logic [31:0] crc_wdata;
		logic [31:0] crc_data;
		logic [2:0] crc_left;
		logic crc_dma;
		logic [31:0] crc_fsrc;
		logic [15:0] crc_fcnt;
		logic [31:0] crc_csrc;
		logic [15:0] crc_ccnt;
		logic [1:0] crc_ie;
		logic [1:0] crc_flg;
	} pdc_st_t;

	pdc_st_t q;
	pdc_st_t d;
	logic [NUM_SRC-1:0] want;
	logic [3:0] gnt;
	logic [3:0] idx;
	logic gnt_ok;
	logic preq;
	logic [3:0] blk;
	logic [7:0] ofs;
	logic [31:0] w;
	logic [31:0] rv;
	logic [2:0] nb;
	logic [31:0] dm;
	logic [15:0] left16;
	logic [7:0] byte_in;

	function automatic logic [7:0] rev8(input logic [7:0] v);
		logic [7:0] r;
		for (int i = 0; i < 8; i++) r[i] = v[7 - i];
		return r;
	endfunction : rev8

	function automatic logic [2:0] wid_bytes(input logic [1:0] pw);
		logic [2:0] r;
		case (pw)
			PW_BYTE: r = 3'h1;
			PW_HALF: r = 3'h2;
			default: r = 3'h4;
		endcase
		return r;
	endfunction : wid_bytes

	function automatic logic [31:0] wid_mask(input logic [2:0] b);
		return (b == 3'h4) ? 32'hffff_ffff : (b == 3'h2) ? 32'h0000_ffff : 32'h0000_00ff;
	endfunction : wid_mask

	// Fold one byte, most significant bit first
	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b, input logic [1:0] p);
		logic [31:0] r;
		logic fb;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			fb = ((r & TOP_TAB[p]) != 32'h0) ^ b[i];
			r = r << 1;
			if (fb) r = r ^ POLY_TAB[p];
		end
		return r & ((TOP_TAB[p] << 1) - 32'h1);
	endfunction : crc_byte

	function automatic logic [31:0] crc_out(input logic [31:0] c, input logic [1:0] p, input logic rvs, input logic cm);
		logic [31:0] m;
		logic [31:0] r;
		logic [31:0] t;
		m = (TOP_TAB[p] << 1) - 32'h1;
		r = c;
		t = 32'h0;
		if (rvs) begin
			for (int i = 0; i < 32; i++) t[i] = r[31 - i];
			r = t >> (32 - WID_TAB[p]);
		end
		if (cm) r = ~r & m;
		return r;
	endfunction : crc_out

	always_comb begin
		d = q;
		d.rdata = 32'h0;
		blk = rb_req.addr[11:8];
		ofs = rb_req.addr[7:0];
		w = rb_req.wdata;
		rv = 32'h0;
		nb = 3'h4;
		dm = 32'hffff_ffff;
		left16 = 16'h0;
		byte_in = 8'h0;
		preq = 1'b0;
		// Register reads
		if (blk < 4'(NUM_CH)) begin
			case (ofs)
				OFS_CTL: rv = {8'h0, q.ch[blk].busy, 2'h0, q.ch[blk].width, 11'h0, q.ch[blk].dstep,
					q.ch[blk].sstep, q.ch[blk].mode, 1'b0, q.ch[blk].en};
				OFS_SRC: rv = q.ch[blk].src;
				OFS_DST: rv = q.ch[blk].dst;
				OFS_CNT: rv = {16'h0, q.ch[blk].cnt};
				OFS_CSRC: rv = q.ch[blk].csrc;
				OFS_CDST: rv = q.ch[blk].cdst;
				OFS_CCNT: rv = {16'h0, q.ch[blk].ccnt};
				OFS_IE: rv = {30'h0, q.ch[blk].ie};
				OFS_IS: rv = {30'h0, q.ch[blk].flg};
				OFS_BUF: rv = q.ch[blk].buffer;
				default: rv = 32'h0;
			endcase
		end else if (blk == BLK_CRC) begin
			case (ofs)
				OFS_CTL: rv = {q.crc_poly, q.crc_wlen, q.crc_ocom, q.crc_icom, q.crc_orev, q.crc_irev,
					q.crc_trig, 21'h0, 1'b0, q.crc_en};
				OFS_SRC: rv = q.crc_fsrc;
				OFS_CNT: rv = {16'h0, q.crc_fcnt};
				OFS_CSRC: rv = q.crc_csrc;
				OFS_CCNT: rv = {16'h0, q.crc_ccnt};
				OFS_IE: rv = {30'h0, q.crc_ie};
				OFS_IS: rv = {30'h0, q.crc_flg};
				OFS_WDATA: rv = q.crc_wdata;
				OFS_SEED: rv = q.crc_seed;
				OFS_SUM: rv = crc_out(q.crc_sum, q.crc_poly, q.crc_orev, q.crc_ocom);
				default: rv = 32'h0;
			endcase
		end else if (blk == BLK_GLB) begin
			case (ofs)
				OFS_SEL0: rv = {q.ch[3].sel, q.ch[2].sel, q.ch[1].sel, q.ch[0].sel};
				OFS_SEL1: rv = {q.ch[7].sel, q.ch[6].sel, q.ch[5].sel, q.ch[4].sel};
				OFS_SEL2: rv = {24'h0, q.ch[8].sel};
				OFS_GIS: begin
					for (int c = 0; c < NUM_CH; c++) rv[c] = |(q.ch[c].flg & q.ch[c].ie);
					rv[B_GIS_CRC] = |(q.crc_flg & q.crc_ie);
				end
				default: rv = 32'h0;
			endcase
		end
		if (rb_req.rd) d.rdata = rv;
		// Channel register writes
		if (rb_req.wr && blk < 4'(NUM_CH)) begin
			case (ofs)
				OFS_CTL: begin
					d.ch[blk].en = w[B_EN];
					d.ch[blk].mode = w[F_MODE+:2];
					d.ch[blk].sstep = w[F_SSTEP+:2];
					d.ch[blk].dstep = w[F_DSTEP+:2];
					d.ch[blk].width = w[F_WID+:2];
					if (!w[B_EN]) d.ch[blk].busy = 1'b0;
					if (w[B_SRST]) begin
						d.ch[blk].busy = 1'b0;
						d.ch[blk].err_hold = 1'b0;
						d.ch[blk].csrc = 32'h0;
						d.ch[blk].cdst = 32'h0;
						d.ch[blk].ccnt = 16'h0;
						d.ch[blk].buffer = 32'h0;
					end else if (w[B_TRIG] && w[B_EN] && !q.ch[blk].err_hold) begin
						d.ch[blk].csrc = q.ch[blk].src;
						d.ch[blk].cdst = q.ch[blk].dst;
						d.ch[blk].ccnt = q.ch[blk].cnt;
						d.ch[blk].busy = (q.ch[blk].cnt != 16'h0);
						if (q.ch[blk].cnt == 16'h0) d.ch[blk].flg[B_DONE] = 1'b1;
					end
				end
				OFS_SRC: d.ch[blk].src = w;
				OFS_DST: d.ch[blk].dst = w;
				OFS_CNT: d.ch[blk].cnt = w[15:0];
				OFS_IE: d.ch[blk].ie = w[1:0];
				OFS_IS: d.ch[blk].flg = q.ch[blk].flg & ~w[1:0];
				default: ;
			endcase
		end
		// Checksum register writes
		if (rb_req.wr && blk == BLK_CRC) begin
			case (ofs)
				OFS_CTL: begin
					d.crc_en = w[B_EN];
					d.crc_irev = w[B_IREV];
					d.crc_orev = w[B_OREV];
					d.crc_icom = w[B_ICOM];
					d.crc_ocom = w[B_OCOM];
					d.crc_wlen = w[F_WLEN+:2];
					d.crc_poly = w[F_POLY+:2];
					d.crc_trig = w[B_TRIG] && w[B_EN];
					if (w[B_SRST]) d.crc_sum = q.crc_seed;
					if (w[B_TRIG] && w[B_EN] && !q.crc_trig) begin
						d.crc_csrc = {q.crc_fsrc[31:2], 2'h0};
						d.crc_ccnt = q.crc_fcnt;
						if (q.crc_fcnt == 16'h0) begin
							d.crc_trig = 1'b0;
							d.crc_flg[B_DONE] = 1'b1;
						end
					end
				end
				OFS_SRC: d.crc_fsrc = w;
				OFS_CNT: d.crc_fcnt = w[15:0];
				OFS_IE: d.crc_ie = w[1:0];
				OFS_IS: d.crc_flg = q.crc_flg & ~w[1:0];
				OFS_SEED: d.crc_seed = w;
				OFS_WDATA: begin
					d.crc_wdata = w;
					if (q.crc_en && !q.crc_trig && q.crc_left == 3'h0) begin
						d.crc_data = w;
						d.crc_dma = 1'b0;
						d.crc_left = (q.crc_wlen == WL_BYTE) ? 3'h1 : (q.crc_wlen == WL_HALF) ? 3'h2 : 3'h4;
					end
				end
				default: ;
			endcase
		end
		// Service selection writes
		if (rb_req.wr && blk == BLK_GLB) begin
			for (int j = 0; j < 4; j++) begin
				if (ofs == OFS_SEL0) d.ch[j].sel = w[8*j+:8];
				if (ofs == OFS_SEL1) d.ch[j+4].sel = w[8*j+:8];
			end
			if (ofs == OFS_SEL2) d.ch[8].sel = w[7:0];
		end
		// Requesters
		for (int c = 0; c < NUM_CH; c++) begin
			preq = (q.ch[c].sel[7:4] == 4'h0) && periph_req[q.ch[c].sel[3:0]];
			want[c] = q.ch[c].en && q.ch[c].busy && q.ch[c].ccnt != 16'h0 && (q.ch[c].mode == MODE_M2M || preq);
		end
		want[CRC_IDX] = q.crc_en && q.crc_trig && q.crc_left == 3'h0 && q.crc_ccnt != 16'h0;
		// Round robin from the source after the last one served
		gnt_ok = 1'b0;
		gnt = 4'h0;
		for (int k = 1; k <= NUM_SRC; k++) begin
			idx = 4'((int'(q.last) + k) % NUM_SRC);
			if (!gnt_ok && want[idx]) begin
				gnt_ok = 1'b1;
				gnt = idx;
			end
		end
		// Transfer sequencer
		case (q.st)
			ST_IDLE: begin
				if (gnt_ok) begin
					d.cur = gnt;
					d.last = gnt;
					d.mb.req = 1'b1;
					d.mb.write = 1'b0;
					if (gnt == CRC_IDX) begin
						d.mb.addr = q.crc_csrc;
						d.mb.size = SZ_WORD;
						d.st = ST_CRC;
					end else begin
						nb = wid_bytes(q.ch[gnt].width);
						d.mb.addr = q.ch[gnt].csrc;
						d.mb.size = {nb[2], nb[1]};
						d.st = ST_READ;
					end
				end
			end
			ST_READ: begin
				if (mb_rsp.ack) begin
					nb = wid_bytes(q.ch[q.cur].width);
					dm = wid_mask(nb);
					if (mb_rsp.err || !d.ch[q.cur].busy) begin
						d.mb.req = 1'b0;
						d.st = ST_IDLE;
						if (mb_rsp.err) begin
							d.ch[q.cur].busy = 1'b0;
							d.ch[q.cur].err_hold = 1'b1;
							d.ch[q.cur].flg[B_ABORT] = 1'b1;
						end
					end else begin
						d.ch[q.cur].buffer = mb_rsp.rdata & dm;
						d.mb.write = 1'b1;
						d.mb.addr = q.ch[q.cur].cdst;
						d.mb.wdata = mb_rsp.rdata & dm;
						d.st = ST_WRITE;
					end
				end
			end
			ST_WRITE: begin
				if (mb_rsp.ack) begin
					nb = wid_bytes(q.ch[q.cur].width);
					d.mb.req = 1'b0;
					d.mb.write = 1'b0;
					d.st = ST_IDLE;
					if (mb_rsp.err) begin
						d.ch[q.cur].busy = 1'b0;
						d.ch[q.cur].err_hold = 1'b1;
						d.ch[q.cur].flg[B_ABORT] = 1'b1;
					end else begin
						if (!q.ch[q.cur].sstep[1]) d.ch[q.cur].csrc = q.ch[q.cur].csrc + {29'h0, nb};
						if (!q.ch[q.cur].dstep[1]) d.ch[q.cur].cdst = q.ch[q.cur].cdst + {29'h0, nb};
						left16 = (q.ch[q.cur].ccnt > {13'h0, nb}) ? q.ch[q.cur].ccnt - {13'h0, nb} : 16'h0;
						d.ch[q.cur].ccnt = left16;
						if (left16 == 16'h0) begin
							d.ch[q.cur].busy = 1'b0;
							d.ch[q.cur].flg[B_DONE] = 1'b1;
						end
					end
				end
			end
			ST_CRC: begin
				if (mb_rsp.ack) begin
					d.mb.req = 1'b0;
					d.st = ST_IDLE;
					if (mb_rsp.err) begin
						d.crc_trig = 1'b0;
						d.crc_flg[B_ABORT] = 1'b1;
					end else begin
						d.crc_data = mb_rsp.rdata;
						d.crc_dma = 1'b1;
						d.crc_left = (q.crc_ccnt >= 16'h4) ? 3'h4 : q.crc_ccnt[2:0];
						d.crc_csrc = q.crc_csrc + 32'h4;
						d.crc_ccnt = (q.crc_ccnt >= 16'h4) ? q.crc_ccnt - 16'h4 : 16'h0;
					end
				end
			end
			default: d.st = ST_IDLE;
		endcase
		// Checksum datapath, one byte per cycle, low byte first
		if (q.crc_left != 3'h0) begin
			byte_in = q.crc_data[7:0];
			if (q.crc_irev) byte_in = rev8(byte_in);
			if (q.crc_icom) byte_in = ~byte_in;
			d.crc_sum = crc_byte(d.crc_sum, byte_in, q.crc_poly);
			d.crc_data = q.crc_data >> 8;
			d.crc_left = q.crc_left - 3'h1;
			if (q.crc_left == 3'h1 && q.crc_dma && q.crc_ccnt == 16'h0) begin
				d.crc_flg[B_DONE] = 1'b1;
				d.crc_trig = 1'b0;
				d.crc_dma = 1'b0;
			end
		end
		// Interrupt line
		d.irq = |(d.crc_flg & d.crc_ie);
		for (int c = 0; c < NUM_CH; c++) begin
			if (|(d.ch[c].flg & d.ch[c].ie)) d.irq = 1'b1;
		end
		// Synchronous reset
		if (!reset_n) begin
			d = '0;
			d.st = ST_IDLE;
			d.last = LAST_RST;
			d.crc_wlen = RST_CHECKSUM_CONTROL[F_WLEN+:2];
			d.crc_poly = RST_CHECKSUM_CONTROL[F_POLY+:2];
			d.crc_seed = RST_SEED;
			d.crc_sum = RST_SUM;
			d.crc_ie = RST_IE;
			for (int c = 0; c < NUM_CH; c++) begin
				d.ch[c].ie = RST_IE;
				d.ch[c].sel = RST_SEL;
			end
		end
	end

	always_ff @(posedge clock) begin
		q <= d;
	end

	assign rb_rdata = q.rdata;
	assign mb_req = q.mb;
	assign irq = q.irq;
endmodule : pdc_engine

// file: pdc_engine_checker.sv
`timescale 1ns/1ps
module pdc_engine_checker import pdc_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register port
	input pdc_rb_req_t rb_req,
	input logic [31:0] rb_rdata,
	// Memory bus
	input pdc_mb_req_t mb_req,
	input pdc_mb_rsp_t mb_rsp,
	// Requests and interrupt
	input wire logic [15:0] periph_req,
	input logic irq
);
	logic rd_done_q;
	logic trig_m2m;
	logic trig_sum;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	assign trig_m2m = rb_req.wr && rb_req.addr[11:8] < 4'h9 && rb_req.addr[7:0] == OFS_CTL
		&& rb_req.wdata[B_EN] && rb_req.wdata[B_TRIG] && rb_req.wdata[F_MODE+:2] == MODE_M2M;
	assign trig_sum = rb_req.wr && rb_req.addr == {BLK_CRC, OFS_CTL} && rb_req.wdata[B_EN] && rb_req.wdata[B_TRIG];
	// Last bus answer was a clean read, so a word is held
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rd_done_q <= 1'b0;
		end else if (mb_rsp.ack) begin
			rd_done_q <= !mb_req.write && !mb_rsp.err;
		end
	end
	a_rdata_quiet:
	assert property (!rb_req.rd |=> rb_rdata == 32'h0) else $error("read data outside answer cycle");
	a_bus_hold:
	assert property (mb_req.req && !mb_rsp.ack |=> mb_req.req && $stable(mb_req)) else $error("bus request moved");
	a_write_after_read:
	assert property (mb_req.req && mb_req.write |-> rd_done_q) else $error("write without held word");
	a_write_gap:
	assert property (mb_rsp.ack && mb_req.write |=> !mb_req.req) else $error("no gap after write");
	a_error_halt:
	assert property (mb_rsp.ack && mb_rsp.err |=> !mb_req.req) else $error("request after error");
	a_trigger_start:
	assert property (trig_m2m |-> ##[1:20] mb_req.req) else $error("trigger did not start");
	a_fetch_start:
	assert property (trig_sum |-> ##[1:20] (mb_req.req && !mb_req.write && mb_req.size == SZ_WORD))
		else $error("checksum fetch did not start");
	a_size_legal:
	assert property (mb_req.req |-> mb_req.size != 2'h3) else $error("illegal access size");
endmodule : pdc_engine_checker

// file: pdc_mem_model.sv
`timescale 1ns/1ps
module pdc_mem_model import pdc_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Bus from the engine
	input pdc_mb_req_t mb_req,
	output pdc_mb_rsp_t mb_rsp,
	// Answer latency
	input wire logic [3:0] delay
);
	logic [31:0] mem [256];
	logic [3:0] wait_q;
	logic [7:0] idx;
	logic [4:0] sh;
	assign idx = mb_req.addr[9:2];
	assign sh = {mb_req.addr[1:0], 3'h0};
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 32'h0;
	end
	always @(posedge clock) begin
		if (!reset_n) begin
			mb_rsp <= '{ack: 1'b0, err: 1'b0, rdata: 32'h5a5a_a5a5};
			wait_q <= 4'h0;
		end else if (mb_rsp.ack || !mb_req.req) begin
			mb_rsp <= '{ack: 1'b0, err: 1'b0, rdata: ~mb_rsp.rdata};
			wait_q <= 4'h0;
		end else if (wait_q < delay) begin
			mb_rsp.rdata <= ~mb_rsp.rdata;
			wait_q <= wait_q + 4'h1;
		end else begin
			mb_rsp.ack <= 1'b1;
			mb_rsp.err <= mb_req.addr[31:28] == 4'hf;
			mb_rsp.rdata <= mem[idx] >> sh;
			if (mb_req.write && mb_req.size == SZ_WORD) mem[idx] <= mb_req.wdata;
			else if (mb_req.write && mb_req.size == 2'h1) mem[idx][{sh[4], 4'h0}+:16] <= mb_req.wdata[15:0];
			else if (mb_req.write) mem[idx][sh+:8] <= mb_req.wdata[7:0];
		end
	end
endmodule : pdc_mem_model

// file: pdc_engine_tb_top.sv
`timescale 1ns/1ps
module pdc_engine_tb_top import pdc_pkg::*;;
	logic clock;
	logic reset_n;
	pdc_rb_req_t rb_req;
	logic [31:0] rb_rdata;
	pdc_mb_req_t mb_req;
	pdc_mb_rsp_t mb_rsp;
	logic [15:0] periph_req;
	logic irq;
	logic [3:0] delay;
	logic [1:0] last_size;
	logic [31:0] rd_q [$];
	int error_cnt = 0;
	int check_count = 0;
	pdc_engine uut (.clock(clock), .reset_n(reset_n), .rb_req(rb_req), .rb_rdata(rb_rdata),
		.mb_req(mb_req), .mb_rsp(mb_rsp), .periph_req(periph_req), .irq(irq));
	pdc_mem_model mem_i (.clock(clock), .reset_n(reset_n), .mb_req(mb_req), .mb_rsp(mb_rsp), .delay(delay));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (mb_req.req && mb_rsp.ack && !mb_req.write) begin
			rd_q.push_back(mb_req.addr);
			last_size <= mb_req.size;
		end
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		rb_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clock);
		rb_req <= '0;
	endtask : reg_wr
	task automatic reg_rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clock);
		rb_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clock);
		rb_req <= '0;
		#1;
		d = rb_rdata;
	endtask : reg_rd
	task automatic chk_reg(input string name, input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		reg_rd(a, d);
		check(name, d, exp);
	endtask : chk_reg
	task automatic wait_flag(input logic [11:0] a, input int b);
		logic [31:0] d;
		for (int i = 0; i < 300; i++) begin
			reg_rd(a, d);
			if (d[b] === 1'b1) return;
		end
		check("flag wait", 32'h0, 32'h1);
	endtask : wait_flag
	task automatic ch_start(input logic [3:0] ch, input logic [31:0] ctl, input logic [31:0] s, input logic [31:0] d,
		input logic [31:0] n);
		reg_wr({ch, OFS_CTL}, ctl);
		reg_wr({ch, OFS_SRC}, s);
		reg_wr({ch, OFS_DST}, d);
		reg_wr({ch, OFS_CNT}, n);
		reg_wr({ch, OFS_CTL}, ctl | 32'h0080_0000);
	endtask : ch_start
	function automatic logic [31:0] crc_ref(input logic [1:0] p, input logic [31:0] s, input logic [31:0] d,
		input int n, input logic [3:0] f);
		logic [31:0] c;
		logic [7:0] b;
		int w;
		w = (p == 2'h1) ? 8 : (p == 2'h3) ? 32 : 16;
		c = s;
		for (int i = 0; i < n; i++) begin
			b = d[8*i+:8];
			if (f[0]) b = {<<{b}};
			if (f[2]) b = ~b;
			c = c ^ (32'(b) << (w - 8));
			for (int k = 0; k < 8; k++) c = c[w-1] ? (c << 1) ^ POLY_TAB[p] : c << 1;
		end
		if (w < 32) c = c & ((32'h1 << w) - 32'h1);
		if (f[1]) c = {<<{c}};
		if (f[1]) c = c >> (32 - w);
		if (f[3]) c = ~c & (32'hffff_ffff >> (32 - w));
		return c;
	endfunction : crc_ref
	task automatic t_reset;
		chk_reg("chan irq enable", 12'h020, 32'h1);
		chk_reg("sum control", 12'he00, RST_CHECKSUM_CONTROL);
		chk_reg("sum result", 12'he88, RST_SUM);
		chk_reg("service select", 12'hf04, 32'hffff_ffff);
		chk_reg("unmapped", 12'h0fc, 32'h0);
		check("irq idle", {31'h0, irq}, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_rr;
		mem_i.mem[64] = 32'ha5a5_0001;
		mem_i.mem[65] = 32'h5a5a_0002;
		reg_wr(12'hf04, 32'hffff_ff01);
		reg_wr(12'hf10, 32'h0000_0001);
		ch_start(4'h0, 32'h25, 32'h100, 32'h180, 32'h8);
		ch_start(4'h8, 32'h25, 32'h104, 32'h1a0, 32'h8);
		rd_q.delete();
		repeat (10) @(posedge clock);
		check("early reads", 32'(rd_q.size()), 32'h0);
		periph_req <= 16'h0002;
		wait_flag(12'h024, 1);
		wait_flag(12'h824, 1);
		@(posedge clock);
		periph_req <= 16'h0000;
		check("grant 0", rd_q[0], 32'h100);
		check("grant 1", rd_q[1], 32'h104);
		check("grant 2", rd_q[2], 32'h100);
		check("ch0 copy", mem_i.mem[97], 32'ha5a5_0001);
		check("ch8 copy", mem_i.mem[105], 32'h5a5a_0002);
		$display("test arbitration done");
	endtask : t_rr
	task automatic t_copy;
		reg_wr(12'h120, 32'h2);
		delay <= 4'h2;
		ch_start(4'h1, 32'h81, 32'h100, 32'h1c0, 32'h8);
		wait_flag(12'h124, 1);
		check("fixed dest", mem_i.mem[112], 32'h5a5a_0002);
		chk_reg("cur src", 12'h114, 32'h108);
		chk_reg("cur dst", 12'h118, 32'h1c0);
		chk_reg("remaining", 12'h11c, 32'h0);
		check("done irq", {31'h0, irq}, 32'h1);
		rd_q.delete();
		reg_wr(12'h124, 32'h2);
		chk_reg("flag cleared", 12'h124, 32'h0);
		check("irq cleared", {31'h0, irq}, 32'h0);
		repeat (20) @(posedge clock);
		check("idle after block", 32'(rd_q.size()), 32'h0);
		chk_reg("busy clear", 12'h100, 32'h81);
		delay <= 4'h0;
		$display("test copy done");
	endtask : t_copy
	task automatic t_width;
		reg_wr(12'hf04, 32'hff02_ff01);
		periph_req <= 16'h0004;
		for (int w = 0; w < 3; w++) begin
			rd_q.delete();
			ch_start(4'h2, 32'h89 | (32'(w) << F_WID), 32'h100, 32'h300, 32'h4);
			wait_flag(12'h224, 1);
			check("items", 32'(rd_q.size()), (w == 0) ? 32'h1 : (w == 1) ? 32'h4 : 32'h2);
			check("item size", {30'h0, last_size}, (w == 0) ? 32'h2 : 32'(w - 1));
			chk_reg("cur src", 12'h214, 32'h104);
			reg_wr(12'h224, 32'h2);
		end
		periph_req <= 16'h0000;
		$display("test width done");
	endtask : t_width
	task automatic t_err;
		ch_start(4'h3, 32'h1, 32'hf000_0000, 32'h1e0, 32'h4);
		wait_flag(12'h324, 0);
		chk_reg("halted", 12'h300, 32'h1);
		chk_reg("no done", 12'h324, 32'h1);
		check("abort irq", {31'h0, irq}, 32'h1);
		reg_wr(12'h324, 32'h3);
		reg_wr(12'h300, 32'h2);
		ch_start(4'h3, 32'h1, 32'h100, 32'h1e0, 32'h4);
		wait_flag(12'h324, 1);
		check("restart copy", mem_i.mem[120], 32'ha5a5_0001);
		reg_wr(12'h324, 32'h2);
		$display("test error done");
	endtask : t_err
	task automatic t_stop;
		logic [31:0] r;
		delay <= 4'h3;
		ch_start(4'h4, 32'h1, 32'h100, 32'h280, 32'h40);
		repeat (20) @(posedge clock);
		reg_wr(12'h400, 32'h0);
		repeat (30) @(posedge clock);
		#1;
		check("bus idle", {31'h0, mb_req.req}, 32'h0);
		reg_rd(12'h41c, r);
		check("count left", {31'h0, r != 32'h0}, 32'h1);
		chk_reg("no done", 12'h424, 32'h0);
		delay <= 4'h0;
		$display("test stop done");
	endtask : t_stop
	task automatic crc_one(input logic [1:0] p, input logic [3:0] f, input logic [1:0] wl, input logic [31:0] d,
		input int n);
		logic [31:0] r;
		reg_wr(12'he84, 32'h1d0f_5a5a);
		reg_wr(12'he00, {p, wl, f, 24'h3});
		reg_wr(12'he80, d);
		repeat (n - 1) @(posedge clock);
		reg_rd(12'he88, r);
		check("checksum", r, crc_ref(p, 32'h1d0f_5a5a, d, n, f));
		chk_reg("sum control", 12'he00, {p, wl, f, 24'h1});
	endtask : crc_one
	task automatic t_crc;
		logic [31:0] e;
		for (int p = 0; p < 4; p++) crc_one(2'(p), 4'h0, SZ_WORD, 32'h3332_3130, 4);
		crc_one(2'h3, 4'hf, SZ_WORD, 32'hc0de_1234, 4);
		crc_one(2'h0, 4'ha, SZ_WORD, 32'h3332_3130, 4);
		crc_one(2'h1, 4'h5, WL_BYTE, 32'h0000_00a7, 1);
		crc_one(2'h0, 4'h0, WL_HALF, 32'h0000_c3e1, 2);
		mem_i.mem[128] = 32'h0403_0201;
		mem_i.mem[129] = 32'h0807_0605;
		e = crc_ref(2'h3, 32'hffff_ffff, 32'h0403_0201, 4, 4'h0);
		e = crc_ref(2'h3, e, 32'h0000_0605, 2, 4'h0);
		rd_q.delete();
		reg_wr(12'he84, 32'hffff_ffff);
		reg_wr(12'he04, 32'h200);
		reg_wr(12'he0c, 32'h6);
		reg_wr(12'he00, 32'hc000_0003);
		reg_wr(12'he00, 32'hc080_0001);
		wait_flag(12'he24, 1);
		chk_reg("fetch sum", 12'he88, e);
		check("fetch reads", 32'(rd_q.size()), 32'h2);
		$display("test checksum done");
	endtask : t_crc
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	initial begin
		#200000;
		error_cnt++;
		conclude();
	end
	initial begin
		reset_n = 1'b0;
		rb_req = '0;
		periph_req = 16'h0;
		delay = 4'h0;
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		t_reset();
		t_rr();
		t_copy();
		t_width();
		t_err();
		t_stop();
		t_crc();
		conclude();
	end
endmodule : pdc_engine_tb_top
bind pdc_engine pdc_engine_checker chk_i (.clock(clock), .reset_n(reset_n), .rb_req(rb_req), .rb_rdata(rb_rdata),
	.mb_req(mb_req), .mb_rsp(mb_rsp), .periph_req(periph_req), .irq(irq));
